/* File: src/arf_filter.sv */
// asynchronous request filter: acceptance, range check and routing
// assumes link logic presents one request per reqValid cycle, synchronous inputs
// Notes on behaviour
// - non-low-ROM requests pick acceptance bit by source
// - acceptance bit zero: no ack, discard
// - acceptance bit one: accept, then route
// - offset at or above limit goes DMA
// - DMA context disabled: drop silently
// - node bit admits alias or local bus
// - remote bit admits any other bus
// - set address sets, clear address clears
// - both addresses read present acceptance bits
// - bus reset clears acceptance words
// - below limit, direct bit picks unit
// - direct node bit matches alias/local bus
// - direct remote bit matches other buses
// - direct words change only by set/clear or bus reset
// - refused direct goes DMA if enabled
// - direct words readable, cleared by bus reset
// - range is zero up to limit
// - limit is high 32 of 48 bits
// - optional limit; absent reads zero, 4GB range
// - ROM quadlet reads, resource registers bypass
// - responses never filtered
// - bus reset sets local bus to 3FF
module arf_filter #(
    parameter bit LIMIT_PRESENT = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic busReset,
    input wire logic dmaEnabled,
    input wire logic reqValid,
    input wire arf_pkg::arf_req_t req,
    output arf_pkg::arf_verdict_t verdict,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import arf_pkg::*;

    arf_state_t st;      // every flop of the block
    arf_state_t next_st; // its next value

    // byte-lane mask from Avalon byteenable
    function automatic logic [31:0] laneMask(input logic [3:0] be);
        laneMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // filter lookup shared by both filter pairs
    function automatic logic filterHit(input logic [31:0] hi, input logic [31:0] lo,
                                       input logic [15:0] src, input logic [9:0] localBus);
        logic [9:0] bus;
        logic [5:0] node;
        logic [63:0] all;
        bus = src[15:6];
        node = src[5:0];
        all = {hi, lo};
        if (bus == LOCAL_BUS_ALIAS || bus == localBus)
            filterHit = all[node];
        else
            filterHit = hi[REMOTE_BIT];
    endfunction

    logic [3:0] wordIdx;     // register index
    logic [31:0] byteMask;   // bits reachable through enabled byte lanes
    logic filtered;          // request is subject to both filters
    logic [31:0] wrBits;
    logic accOk;
    logic dirOk;
    logic [47:0] rangeEnd;
    logic inRange;

    assign wordIdx = avs_address[5:2];
    // a part-select of a function result is not legal, so the mask gets its own net
    assign byteMask = laneMask(avs_byteenable);
    // everything outside the bypass cases goes through the filters
    assign filtered = !req.isResponse && !req.isRomQuadRead && !req.isResourceReg
                      && req.offset >= ROM_LOW_END;
    assign wrBits = avs_writedata & laneMask(avs_byteenable);

    // limit as 48-bit, low 16 bits zero; absent limit gives 4GB
    assign rangeEnd = LIMIT_PRESENT ? {st.limit, 16'h0000} : LIMIT_ABSENT;
    assign inRange = req.offset < rangeEnd;
    assign accOk = filterHit(st.accHi, st.accLo, req.sourceId, st.localBus);
    assign dirOk = filterHit(st.dirHi, st.dirLo, req.sourceId, st.localBus);

    // read answer one cycle after request; waitrequest until then
    assign avs_waitrequest = (avs_read || avs_write) && !st.readValid;
    assign avs_readdata = st.readData;
    assign verdict = st.verdict;

    // next-state logic
    always_comb
    begin
        next_st = st;
        next_st.readValid = 1'b0;
        next_st.verdict = '{valid: 1'b0, ack: 1'b0, route: ROUTE_DROP};
        // register access: first cycle latches read data, second cycle completes
        if ((avs_read || avs_write) && !st.readValid)
        begin
            next_st.readValid = 1'b1;
            // reads return present state at either address
            case (wordIdx)
                ACC_HI_SET, ACC_HI_CLR: next_st.readData = st.accHi;
                ACC_LO_SET, ACC_LO_CLR: next_st.readData = st.accLo;
                DIR_HI_SET, DIR_HI_CLR: next_st.readData = st.dirHi;
                DIR_LO_SET, DIR_LO_CLR: next_st.readData = st.dirLo;
                RANGE_LIM: next_st.readData = LIMIT_PRESENT ? st.limit : LIMIT_RESET;
                BUS_CTRL: next_st.readData = {22'h00_0000, st.localBus};
                default: next_st.readData = 32'h0000_0000;
            endcase
        end
        // writes land only at the edge where waitrequest is seen low,
        // so a master that abandons a stalled write changes nothing
        if (avs_write && st.readValid)
        begin
            begin
                case (wordIdx)
                    ACC_HI_SET: next_st.accHi = st.accHi | wrBits;
                    ACC_HI_CLR: next_st.accHi = st.accHi & ~wrBits;
                    ACC_LO_SET: next_st.accLo = st.accLo | wrBits;
                    ACC_LO_CLR: next_st.accLo = st.accLo & ~wrBits;
                    DIR_HI_SET: next_st.dirHi = st.dirHi | wrBits;
                    DIR_HI_CLR: next_st.dirHi = st.dirHi & ~wrBits;
                    DIR_LO_SET: next_st.dirLo = st.dirLo | wrBits;
                    DIR_LO_CLR: next_st.dirLo = st.dirLo & ~wrBits;
                    RANGE_LIM:
                    begin
                        if (LIMIT_PRESENT)
                            next_st.limit = (st.limit & ~laneMask(avs_byteenable)) | wrBits;
                    end
                    BUS_CTRL: next_st.localBus = (avs_writedata[9:0] & byteMask[9:0])
                                               | (st.localBus & ~byteMask[9:0]);
                    default: ;
                endcase
            end
        end
        // request verdict, one cycle after reqValid
        if (reqValid)
        begin
            next_st.verdict.valid = 1'b1;
            // bypass cases; low ROM is always open
            if (req.isResponse || req.isRomQuadRead || req.isResourceReg || req.offset < ROM_LOW_END)
            begin
                next_st.verdict.ack = 1'b1;
                next_st.verdict.route = ROUTE_BYPASS;
            end
            else if (!accOk)
            begin
                next_st.verdict.route = ROUTE_DROP;
            end
            // accepted, direct when in range and allowed
            else if (inRange && dirOk)
            begin
                next_st.verdict.ack = 1'b1;
                next_st.verdict.route = ROUTE_DIRECT;
            end
            // to DMA, or dropped when disabled
            else
            begin
                next_st.verdict.ack = dmaEnabled;
                next_st.verdict.route = dmaEnabled ? ROUTE_DMA : ROUTE_DROP;
            end
        end
        // bus reset clears filters, resets bus number
        if (busReset)
        begin
            next_st.accHi = FILTER_RESET;
            next_st.accLo = FILTER_RESET;
            next_st.dirHi = FILTER_RESET;
            next_st.dirLo = FILTER_RESET;
            next_st.localBus = LOCAL_BUS_ALIAS;
        end
    end

    // state register
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            st <= '0;
            st.localBus <= LOCAL_BUS_ALIAS;
            st.limit <= LIMIT_RESET;
        end
        else
            st <= next_st;
    end

    a_refuse_noack: assert property (@(posedge ref_clk) disable iff (rst)
        reqValid && !req.isResponse && !req.isRomQuadRead && !req.isResourceReg
        && req.offset >= ROM_LOW_END && !accOk && !busReset |=> !verdict.ack)
        else $error("refused request was acknowledged");
    a_reset_clears: assert property (@(posedge ref_clk) disable iff (rst)
        busReset |=> st.accHi == 32'h0000_0000 && st.accLo == 32'h0000_0000)
        else $error("acceptance words not cleared");
    // direct words cleared after bus reset
    a_direct_clears: assert property (@(posedge ref_clk) disable iff (rst)
        busReset |=> st.dirHi == 32'h0000_0000 && st.dirLo == 32'h0000_0000)
        else $error("direct words not cleared");
    a_bus_alias: assert property (@(posedge ref_clk) disable iff (rst)
        busReset |=> st.localBus == 10'h3FF)
        else $error("local bus number not reset");
    a_dma_off: assert property (@(posedge ref_clk) disable iff (rst)
        !dmaEnabled && reqValid |=> verdict.route != ROUTE_DMA)
        else $error("request sent to disabled DMA context");
    a_range_dma: assert property (@(posedge ref_clk) disable iff (rst)
        reqValid && !inRange |=> verdict.route != ROUTE_DIRECT)
        else $error("out-of-range request sent direct");
    a_resp_pass: assert property (@(posedge ref_clk) disable iff (rst)
        reqValid && req.isResponse |=> verdict.route == ROUTE_BYPASS && verdict.ack)
        else $error("response was filtered");
    a_set_write: assert property (@(posedge ref_clk) disable iff (rst)
        avs_write && !avs_waitrequest && wordIdx == ACC_LO_SET && !busReset
        && avs_byteenable == 4'hF |=> (st.accLo & $past(avs_writedata)) == $past(avs_writedata))
        else $error("set write did not set bits");
    a_read_state: assert property (@(posedge ref_clk) disable iff (rst)
        avs_read && !st.readValid && wordIdx == ACC_HI_CLR |=> avs_readdata == $past(st.accHi))
        else $error("read data not filter state");

    // every request gets exactly one verdict, one cycle later
    a_verdict_pulse: assert property (@(posedge ref_clk) disable iff (rst)
        reqValid |=> verdict.valid)
        else $error("request got no verdict");

    // no verdict without a request
    a_no_spurious: assert property (@(posedge ref_clk) disable iff (rst)
        !reqValid |=> !verdict.valid)
        else $error("verdict without request");

    // a dropped request is never acknowledged
    a_drop_noack: assert property (@(posedge ref_clk) disable iff (rst)
        verdict.route == ROUTE_DROP |-> !verdict.ack)
        else $error("dropped request acknowledged");

    // acknowledge only travels with a verdict
    a_ack_valid: assert property (@(posedge ref_clk) disable iff (rst)
        verdict.ack |-> verdict.valid)
        else $error("acknowledge without verdict");

    // low config area stays open whatever the filters hold
    a_rom_open: assert property (@(posedge ref_clk) disable iff (rst)
        reqValid && req.offset < ROM_LOW_END |=> verdict.ack && verdict.route == ROUTE_BYPASS)
        else $error("low config request filtered");

    // config quadlet reads skip the filters
    a_rom_read: assert property (@(posedge ref_clk) disable iff (rst)
        reqValid && req.isRomQuadRead |=> verdict.route == ROUTE_BYPASS)
        else $error("config read filtered");

    // resource register accesses skip the filters
    a_resource_pass: assert property (@(posedge ref_clk) disable iff (rst)
        reqValid && req.isResourceReg |=> verdict.route == ROUTE_BYPASS)
        else $error("resource access filtered");

    // accepted and out of range goes to an enabled DMA context
    a_out_dma: assert property (@(posedge ref_clk) disable iff (rst)
        reqValid && filtered && accOk && !inRange && dmaEnabled |=> verdict.route == ROUTE_DMA && verdict.ack)
        else $error("out-of-range request not sent to DMA");

    // accepted, in range and allowed goes direct
    a_direct_in: assert property (@(posedge ref_clk) disable iff (rst)
        reqValid && filtered && accOk && inRange && dirOk |=> verdict.route == ROUTE_DIRECT && verdict.ack)
        else $error("allowed request not sent direct");

    // refused by the direct filter, DMA enabled: DMA
    a_refused_dma: assert property (@(posedge ref_clk) disable iff (rst)
        reqValid && filtered && accOk && inRange && !dirOk && dmaEnabled |=> verdict.route == ROUTE_DMA)
        else $error("direct refusal not sent to DMA");

    // refused by the direct filter, DMA disabled: dropped
    a_refused_drop: assert property (@(posedge ref_clk) disable iff (rst)
        reqValid && filtered && accOk && inRange && !dirOk && !dmaEnabled
        |=> verdict.route == ROUTE_DROP && !verdict.ack)
        else $error("direct refusal not dropped");

    // a zero limit leaves no direct range at all
    a_limit_zero: assert property (@(posedge ref_clk) disable iff (rst)
        LIMIT_PRESENT && st.limit == 32'h0000_0000 |-> !inRange)
        else $error("range open with zero limit");

    // remote source without the remote bit is refused
    a_remote_acc: assert property (@(posedge ref_clk) disable iff (rst)
        reqValid && filtered && req.sourceId[15:6] != LOCAL_BUS_ALIAS && req.sourceId[15:6] != st.localBus
        && !st.accHi[REMOTE_BIT] |=> !verdict.ack)
        else $error("remote source accepted");

    // clear address clears the acceptance high word
    a_acc_hi_clear: assert property (@(posedge ref_clk) disable iff (rst)
        avs_write && !avs_waitrequest && wordIdx == ACC_HI_CLR && !busReset
        && avs_byteenable == 4'hF |=> (st.accHi & $past(avs_writedata)) == 32'h0000_0000)
        else $error("clear write did not clear bits");

    // clear address clears the acceptance low word
    a_acc_lo_clear: assert property (@(posedge ref_clk) disable iff (rst)
        avs_write && !avs_waitrequest && wordIdx == ACC_LO_CLR && !busReset
        && avs_byteenable == 4'hF |=> (st.accLo & $past(avs_writedata)) == 32'h0000_0000)
        else $error("clear write did not clear low bits");

    // set address sets the direct low word
    a_dir_set: assert property (@(posedge ref_clk) disable iff (rst)
        avs_write && !avs_waitrequest && wordIdx == DIR_LO_SET && !busReset
        && avs_byteenable == 4'hF |=> (st.dirLo & $past(avs_writedata)) == $past(avs_writedata))
        else $error("direct set write did not set bits");

    // clear address clears the direct high word
    a_dir_hi_clear: assert property (@(posedge ref_clk) disable iff (rst)
        avs_write && !avs_waitrequest && wordIdx == DIR_HI_CLR && !busReset
        && avs_byteenable == 4'hF |=> (st.dirHi & $past(avs_writedata)) == 32'h0000_0000)
        else $error("direct clear write did not clear bits");

    // clear address clears the direct low word
    a_dir_lo_clear: assert property (@(posedge ref_clk) disable iff (rst)
        avs_write && !avs_waitrequest && wordIdx == DIR_LO_CLR && !busReset
        && avs_byteenable == 4'hF |=> (st.dirLo & $past(avs_writedata)) == 32'h0000_0000)
        else $error("direct clear write did not clear low bits");

    // a stalled write leaves the acceptance words alone
    a_stall_nowrite: assert property (@(posedge ref_clk) disable iff (rst)
        avs_write && avs_waitrequest && !busReset
        |=> st.accHi == $past(st.accHi) && st.accLo == $past(st.accLo))
        else $error("write landed while stalled");

    // one wait cycle per access
    a_one_wait: assert property (@(posedge ref_clk) disable iff (rst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("access stalled too long");

    // direct word read returns state
    a_read_direct: assert property (@(posedge ref_clk) disable iff (rst)
        avs_read && !st.readValid && wordIdx == DIR_LO_CLR |=> avs_readdata == $past(st.dirLo))
        else $error("read data not direct state");

    // limit reads back, or zero when absent
    a_limit_read: assert property (@(posedge ref_clk) disable iff (rst)
        avs_read && !st.readValid && wordIdx == RANGE_LIM
        |=> avs_readdata == (LIMIT_PRESENT ? $past(st.limit) : 32'h0000_0000))
        else $error("limit read wrong");

    // local bus number is software-writable
    a_bus_write: assert property (@(posedge ref_clk) disable iff (rst)
        avs_write && !avs_waitrequest && wordIdx == BUS_CTRL && !busReset
        && avs_byteenable == 4'hF |=> st.localBus == $past(avs_writedata[9:0]))
        else $error("local bus number not written");
endmodule

/* File: src/arf_pkg.sv */
// package for the asynchronous request filter block
// assumes one 200 MHz clock and an Avalon-MM register slave
package arf_pkg;
    // register word addresses (byte address = 4 * index)
    localparam logic [3:0] ACC_HI_SET = 4'h0;
    localparam logic [3:0] ACC_HI_CLR = 4'h1;
    localparam logic [3:0] ACC_LO_SET = 4'h2;
    localparam logic [3:0] ACC_LO_CLR = 4'h3;
    localparam logic [3:0] DIR_HI_SET = 4'h4;
    localparam logic [3:0] DIR_HI_CLR = 4'h5;
    localparam logic [3:0] DIR_LO_SET = 4'h6;
    localparam logic [3:0] DIR_LO_CLR = 4'h7;
    localparam logic [3:0] RANGE_LIM = 4'h8;
    localparam logic [3:0] BUS_CTRL = 4'h9;
    // constants
    localparam logic [9:0] LOCAL_BUS_ALIAS = 10'h3FF;
    localparam logic [31:0] FILTER_RESET = 32'h0000_0000;
    localparam logic [31:0] LIMIT_RESET = 32'h0000_0000;
    localparam logic [47:0] ROM_LOW_END = 48'h0000_0000_0400;
    localparam logic [47:0] LIMIT_ABSENT = 48'h0001_0000_0000;
    localparam int REMOTE_BIT = 31;

    // request from the link receive side
    typedef struct packed {
        logic [15:0] sourceId;
        logic [47:0] offset;
        logic isResponse;
        logic isRomQuadRead;
        logic isResourceReg;
    } arf_req_t;

    // routing verdict
    typedef enum logic [1:0] {ROUTE_DROP, ROUTE_DMA, ROUTE_DIRECT, ROUTE_BYPASS} arf_route_t;

    typedef struct packed {
        logic valid;
        logic ack;
        arf_route_t route;
    } arf_verdict_t;

    // whole block state
    typedef struct packed {
        logic [31:0] accHi;
        logic [31:0] accLo;
        logic [31:0] dirHi;
        logic [31:0] dirLo;
        logic [31:0] limit;
        logic [9:0] localBus;
        logic [31:0] readData;
        logic readValid;
        arf_verdict_t verdict;
    } arf_state_t;
endpackage

/* File: verification/arf_link_model.sv */
// link receive side: presents one request for one cycle per go pulse
// assumes go is raised by the bench for one cycle after a rising edge
module arf_link_model (
    input wire logic ref_clk,
    input wire logic go,
    input wire arf_pkg::arf_req_t nextReq,
    output logic reqValid,
    output arf_pkg::arf_req_t req
);
    import arf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        reqValid = 1'b0;
        req = '0;
    end
    // fields flip when idle so stale data never looks like a fresh request
    always @(posedge ref_clk)
    begin
        reqValid <= go;
        req <= go ? nextReq : ~req;
    end
endmodule

/* File: verification/test_arf_filter.sv */
// bench for the request filter: register tasks over Avalon-MM and routing checks
// assumes the filter answers each access after one wait cycle
module test_arf_filter import arf_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic busReset = 1'b0;
    logic dmaEnabled = 1'b1;
    logic go = 1'b0;
    arf_req_t nextReq = '0;
    logic reqValid;
    arf_req_t req;
    arf_verdict_t verdict;
    logic [5:0] avsAddress = 6'h00;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h0000_0000;
    logic [3:0] avsByteEnable = 4'hF;
    logic [31:0] avsReadData;
    logic avsWaitRequest;
    logic [31:0] rdata;
    int errors = 0;
    int nChecks = 0;
    always #2.5 ref_clk = ~ref_clk;
    arf_link_model link (.ref_clk(ref_clk), .go(go), .nextReq(nextReq), .reqValid(reqValid), .req(req));
    arf_filter DUT (.ref_clk(ref_clk), .rst(rst), .busReset(busReset), .dmaEnabled(dmaEnabled),
        .reqValid(reqValid), .req(req), .verdict(verdict), .avs_address(avsAddress), .avs_read(avsRead),
        .avs_write(avsWrite), .avs_writedata(avsWriteData), .avs_byteenable(avsByteEnable),
        .avs_readdata(avsReadData), .avs_waitrequest(avsWaitRequest));
    task automatic give_verdict();
        $display("checks %0d errors %0d", nChecks, errors);
        if (errors == 0 && nChecks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic checkV(input logic [2:0] got, input logic [2:0] exp);
        nChecks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t verdict %h exp %h", $time, got, exp);
        end
    endtask
    // one access held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
        int n;
        avsAddress <= {idx, 2'b00};
        avsRead <= !wr;
        avsWrite <= wr;
        avsWriteData <= wd;
        for (n = 0; n < 20; n++)
        begin
            @(posedge ref_clk);
            if (avsWaitRequest === 1'b0)
                break;
        end
        rdata = avsReadData;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        if (n == 20)
        begin
            errors++;
            give_verdict();
        end
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0000_0000);
        check32(rdata, exp);
    endtask
    task automatic wr(input logic [3:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask
    // flags are isResponse, isRomQuadRead, isResourceReg
    task automatic send(input logic [15:0] src, input logic [47:0] ofs, input logic [2:0] fl,
        input logic ack, input arf_route_t rt);
        int n;
        nextReq <= {src, ofs, fl};
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        for (n = 0; n < 4; n++)
        begin
            @(posedge ref_clk);
            #1;
            if (verdict.valid === 1'b1)
                break;
        end
        if (n == 4)
        begin
            errors++;
            give_verdict();
        end
        checkV({verdict.ack, verdict.route}, {ack, rt});
        @(posedge ref_clk);
    endtask
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 9; i++)
            rd(i[3:0], 32'h0000_0000);
        rd(BUS_CTRL, 32'h0000_03FF);
        rd(4'hA, 32'h0000_0000);
        wr(ACC_LO_SET, 32'h0000_0005);
        rd(ACC_LO_SET, 32'h0000_0005);
        wr(ACC_LO_CLR, 32'h0000_0001);
        rd(ACC_LO_CLR, 32'h0000_0004);
        send({10'h3FF, 6'h02}, 48'h0000_0000_1000, 3'h0, 1'b1, ROUTE_DMA);
        send({10'h3FF, 6'h03}, 48'h0000_0000_1000, 3'h0, 1'b0, ROUTE_DROP);
        send({10'h005, 6'h02}, 48'h0000_0000_1000, 3'h0, 1'b0, ROUTE_DROP);
        wr(ACC_HI_SET, 32'h8000_0000);
        send({10'h005, 6'h02}, 48'h0000_0000_1000, 3'h0, 1'b1, ROUTE_DMA);
        dmaEnabled <= 1'b0;
        send({10'h3FF, 6'h02}, 48'h0000_0000_1000, 3'h0, 1'b0, ROUTE_DROP);
        dmaEnabled <= 1'b1;
        wr(RANGE_LIM, 32'h0000_0001);
        rd(RANGE_LIM, 32'h0000_0001);
        send({10'h3FF, 6'h02}, 48'h0000_0000_8000, 3'h0, 1'b1, ROUTE_DMA);
        dmaEnabled <= 1'b0;
        send({10'h3FF, 6'h02}, 48'h0000_0000_8000, 3'h0, 1'b0, ROUTE_DROP);
        dmaEnabled <= 1'b1;
        wr(DIR_LO_SET, 32'h0000_0004);
        send({10'h3FF, 6'h02}, 48'h0000_0000_FFFF, 3'h0, 1'b1, ROUTE_DIRECT);
        send({10'h3FF, 6'h02}, 48'h0000_0001_0000, 3'h0, 1'b1, ROUTE_DMA);
        wr(DIR_HI_SET, 32'h8000_0000);
        send({10'h005, 6'h02}, 48'h0000_0000_8000, 3'h0, 1'b1, ROUTE_DIRECT);
        wr(DIR_HI_CLR, 32'h8000_0000);
        rd(DIR_HI_SET, 32'h0000_0000);
        send({10'h3FF, 6'h09}, 48'h0000_0000_0100, 3'h0, 1'b1, ROUTE_BYPASS);
        send({10'h3FF, 6'h09}, 48'h0000_0000_8000, 3'h4, 1'b1, ROUTE_BYPASS);
        send({10'h3FF, 6'h09}, 48'h0000_0000_8000, 3'h2, 1'b1, ROUTE_BYPASS);
        send({10'h3FF, 6'h09}, 48'h0000_0000_8000, 3'h1, 1'b1, ROUTE_BYPASS);
        avsByteEnable <= 4'h1;
        wr(ACC_HI_SET, 32'hFFFF_FFFF);
        avsByteEnable <= 4'hF;
        rd(ACC_HI_SET, 32'h8000_00FF);
        wr(BUS_CTRL, 32'h0000_0005);
        send({10'h005, 6'h03}, 48'h0000_0000_1000, 3'h0, 1'b0, ROUTE_DROP);
        busReset <= 1'b1;
        @(posedge ref_clk);
        busReset <= 1'b0;
        @(posedge ref_clk);
        rd(ACC_LO_SET, 32'h0000_0000);
        rd(ACC_HI_CLR, 32'h0000_0000);
        rd(DIR_LO_CLR, 32'h0000_0000);
        rd(BUS_CTRL, 32'h0000_03FF);
        give_verdict();
    end
endmodule
